// ==== inc/smbra_pkg.sv ====
/*
  Constants shared by the SMBus RAM/EEPROM access slave: slave address,
  command codes, memory map, PEC polynomial and busy times.
  Assumes a 250 MHz core clock; times are turned into cycle counts here.
*/
package smbra_pkg;
  // ************************************************************
  // Addressing and command codes
  // ************************************************************
  localparam logic [4:0] SLV_ADDR_HI = 5'h0d;
  localparam logic [7:0] RAM_TOP = 8'hdf;
  localparam logic [7:0] EE_HI_MIN = 8'hf8;
  localparam logic [7:0] EE_HI_MAX = 8'hfb;
  localparam logic [5:0] EE_HI_TAG = 6'h3e;
  localparam logic [7:0] CMD_BLK_WR = 8'hfc;
  localparam logic [7:0] CMD_BLK_RD = 8'hfd;
  localparam logic [7:0] CMD_ERASE = 8'hfe;
  localparam logic [7:0] BLK_RD_COUNT = 8'h20;
  localparam logic [5:0] BLK_MAX = 6'h20;
  localparam logic [5:0] PEC_IDX = 6'h21;
  localparam logic [7:0] UPDATE_CONFIG_REG_ADDR = 8'h90;
  localparam int ERASE_EN_BIT = 2;
  localparam int RAM_DEPTH = 224;
  localparam int EE_DEPTH = 1024;
  localparam int PAGE_BYTES = 32;
  localparam logic [7:0] EE_ERASED = 8'hff;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [7:0] PEC_RESET = 8'h00;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 250;
  localparam int PROG_US = 250;
  localparam int ERASE_MS = 20;
  localparam int PROG_CYC = PROG_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_MS * 1000 * CLK_MHZ;
  localparam int BUSY_W = 23;
endpackage

// ==== inc/smbra_link_if.sv ====
/*
  Carrier between the SCL-clocked shift register and the core logic.
  Assumes the core only reads the byte while SCL is stable.
*/
`timescale 1ns/10ps
interface smbra_link_if;
  logic [7:0] sh;
  modport lnk (output sh);
  modport core (input sh);
endinterface

// ==== core/smbra_link.sv ====
/*
  Bus-clocked capture of SDA on each rising SCL edge.
  Assumes the core samples the byte only after a synchronised SCL rise.
*/
`timescale 1ns/10ps
module smbra_link (
  input wire logic scl_clk_in,
  input wire logic sda_in,
  smbra_link_if.lnk lk
);
  typedef struct packed {
    logic [7:0] sh;
  } smbra_link_s;

  smbra_link_s r;
  smbra_link_s n;

  // Shift in MSB first; no reset since SCL may stand still
  always_comb begin
    n = r;
    n.sh = {r.sh[6:0], sda_in};
  end

  always_ff @(posedge scl_clk_in) begin
    r <= n;
  end

  assign lk.sh = r.sh;
endmodule

// ==== core/smbra_pec.sv ====
/*
  Running CRC-8 packet error check over every byte on the bus.
  Assumes clear and enable never arrive in the same cycle.
*/
`timescale 1ns/10ps
module smbra_pec (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clr_in,
  input wire logic en_in,
  input wire logic [7:0] data_in,
  output logic [7:0] crc_out
);
  typedef struct packed {
    logic [7:0] crc;
  } smbra_pec_s;

  smbra_pec_s r;
  smbra_pec_s n;

  // One byte MSB first, polynomial x^8+x^2+x+1
  function automatic logic [7:0] smbra_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] v;
    v = c ^ d;
    for (int i = 0; i < 8; i++) begin
      v = v[7] ? ((v << 1) ^ smbra_pkg::PEC_POLY) : (v << 1);
    end
    return v;
  endfunction

  always_comb begin
    n = r;
    if (clr_in) begin
      n.crc = smbra_pkg::PEC_RESET;
    end else if (en_in) begin
      n.crc = smbra_crc8(r.crc, data_in);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign crc_out = r.crc;
endmodule

// ==== core/smbra_slave.sv ====
/*
  SMBus slave giving a host byte and block access to register RAM and
  EEPROM, with clock stretching while programming and optional PEC.
  Assumes SCL is a clock port of its own, SDA/SCL are open drain outside,
  and the core clock is far faster than the bus.
*/
// Functional notes
// (RL1) Write byte/word: address, command, one or two data bytes, all acked.
// (RL2) Command within RAM range plus one data byte writes that RAM byte.
// (RL3) EEPROM high command plus one data byte loads the 16-bit pointer.
// (RL4) EEPROM high command plus two data bytes programs the second byte.
// (RL5) Erase picks the page from the low byte's upper three bits; the code also uses pointer bits 9:8.
// (RL6) Block write 0xFC: count, then N bytes stored from the pointer.
// (RL7) Master sends no more than 32 bytes in a block write.
// (RL8) Master sets the start address before any block write.
// (RL9) Master keeps an EEPROM block below the top address.
// (RL10) Master erases every touched page before a block write.
// (RL11) SCL is held low while an EEPROM byte programs.
// (RL12) Receive byte returns one byte from the pointer; master nacks.
// (RL13) Block read: command 0xFD, repeated start, read address, all acked.
// (RL14) Block read returns count 0x20 then 32 data bytes.
// (RL15) Master sets the start address before any read.
// (RL16) Optional PEC byte follows writes and block reads.
// (RL17) PEC is CRC-8, polynomial x^8+x^2+x+1, over the whole transfer.
// (RL18) Master nacks after the PEC byte and retries on a bad check.
// (RL19) Slave address is 01101 plus the two address-select pins.
// (RL20) Send byte 0xFE starts a page erase; others set the RAM pointer; the code sets it only for commands below 0xFC.
// (RL21) Erase happens only with bit 2 of the update config register set.
// (RL22) Every access is nacked while a page erase runs.
// (RL23) Pointer advances by one per block read or block write byte.
`timescale 1ns/10ps
module smbra_slave #(
  parameter int unsigned PROG_CYC = smbra_pkg::PROG_CYC,
  parameter int unsigned ERASE_CYC = smbra_pkg::ERASE_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic scl_clk_in,
  input wire logic sda_in,
  input wire logic addr_select_hi_pin_in,
  input wire logic addr_select_lo_pin_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic scl_out,
  output logic scl_oe_out
);
  // ************************************************************
  // Types and state
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX, ST_SKIP} smbra_st_e;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic scl_q;
    logic sda_q;
    smbra_st_e st;
    logic [3:0] bitn;
    logic [5:0] byten;
    logic ackme;
    logic sda_drv;
    logic stretch;
    logic [7:0] txsh;
    logic [7:0] cmd;
    logic [7:0] bcnt;
    logic [15:0] ptr;
    logic blkrd;
    logic [smbra_pkg::BUSY_W-1:0] busy;
    logic erasing;
  } smbra_core_s;

  smbra_core_s r;
  smbra_core_s n;

  logic [7:0] ram [0:smbra_pkg::RAM_DEPTH-1];
  logic [7:0] ee [0:smbra_pkg::EE_DEPTH-1];

  logic scl_s;
  logic sda_s;
  logic ev_rise;
  logic ev_fall;
  logic ev_start;
  logic ev_stop;
  logic [7:0] rx_byte;
  logic [7:0] mem_rd;
  logic [7:0] crc;
  logic crc_clr;
  logic crc_en;
  logic wr_en;
  logic [15:0] wr_addr;
  logic [7:0] wr_data;
  logic erase_go;
  logic erase_en;
  logic [5:0] k_idx;
  logic [5:0] blk_idx;

  smbra_link_if lk ();

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic is_ram(input logic [15:0] a);
    return (a[15:8] == 8'h00) && (a[7:0] <= smbra_pkg::RAM_TOP);
  endfunction

  function automatic logic is_ee(input logic [15:0] a);
    return a[15:10] == smbra_pkg::EE_HI_TAG;
  endfunction

  function automatic logic is_ee_hi(input logic [7:0] c);
    return (c >= smbra_pkg::EE_HI_MIN) && (c <= smbra_pkg::EE_HI_MAX);
  endfunction

  // ************************************************************
  // Submodules
  // ************************************************************
  smbra_link u_link (
    .scl_clk_in(scl_clk_in),
    .sda_in(sda_in),
    .lk(lk.lnk)
  );

  // PEC runs over every byte seen on the wire, ours included
  // (RL17) CRC over transfer
  smbra_pec u_pec (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clr_in(crc_clr),
    .en_in(crc_en),
    .data_in(rx_byte),
    .crc_out(crc)
  );

  // ************************************************************
  // Bus condition decode
  // ************************************************************
  // Second synchroniser stage only; the first stage feeds nothing else
  assign scl_s = r.s2[3];
  assign sda_s = r.s2[2];
  assign ev_rise = scl_s & ~r.scl_q;
  assign ev_fall = ~scl_s & r.scl_q;
  assign ev_start = scl_s & r.scl_q & r.sda_q & ~sda_s;
  assign ev_stop = scl_s & r.scl_q & ~r.sda_q & sda_s;
  // Byte is stable here: SCL rose several core cycles ago
  assign rx_byte = lk.sh;

  // (RL21) Erase enable bit
  assign erase_en = ram[smbra_pkg::UPDATE_CONFIG_REG_ADDR][smbra_pkg::ERASE_EN_BIT];

  // Read port follows the shared pointer; unmapped reads return zero
  always_comb begin
    mem_rd = 8'h00;
    if (is_ram(r.ptr)) begin
      mem_rd = ram[r.ptr[7:0]];
    end else if (is_ee(r.ptr)) begin
      mem_rd = ee[r.ptr[9:0]];
    end
  end

  assign k_idx = r.byten - 6'h01;
  assign blk_idx = r.byten - 6'h03;

  // ************************************************************
  // Transaction engine
  // ************************************************************
  always_comb begin
    n = r;
    crc_clr = 1'b0;
    crc_en = 1'b0;
    wr_en = 1'b0;
    wr_addr = r.ptr;
    wr_data = rx_byte;
    erase_go = 1'b0;

    // Two flops on every pin before use
    n.s1 = {scl_clk_in, sda_in, addr_select_hi_pin_in, addr_select_lo_pin_in};
    n.s2 = r.s1;
    n.scl_q = scl_s;
    n.sda_q = sda_s;

    // Busy timer shared by program and erase
    if (r.busy != '0) begin
      n.busy = r.busy - 1'b1;
    end else begin
      n.erasing = 1'b0;
    end
    // (RL11) Release stretch
    if (r.stretch && (r.busy == '0)) begin
      n.stretch = 1'b0;
    end

    if (ev_start) begin
      // Repeated start keeps the PEC running across the read phase
      if (r.st == ST_IDLE) begin
        crc_clr = 1'b1;
      end
      n.st = ST_RX;
      n.bitn = 4'h0;
      n.byten = 6'h00;
      n.ackme = 1'b0;
      n.sda_drv = 1'b0;
    end else if (ev_stop) begin
      // (RL20) Send byte sets RAM pointer
      if ((r.st == ST_RX) && (r.byten == 6'h02) && (r.cmd < smbra_pkg::CMD_BLK_WR)) begin
        n.ptr = {8'h00, r.cmd};
      end
      n.st = ST_IDLE;
      n.sda_drv = 1'b0;
      n.blkrd = 1'b0;
    end else if (ev_rise && ((r.st == ST_RX) || (r.st == ST_TX))) begin
      n.bitn = (r.bitn == 4'h8) ? 4'h0 : r.bitn + 4'h1;
      if (r.bitn == 4'h7) begin
        // Eighth bit: a whole byte sits in the shift register
        crc_en = 1'b1;
        if (r.byten != 6'h3f) begin
          n.byten = r.byten + 6'h01;
        end
        if (r.byten == 6'h00) begin
          // (RL19) Address match
          // (RL22) Nack while erasing
          if ((rx_byte[7:1] == {smbra_pkg::SLV_ADDR_HI, r.s2[1], r.s2[0]}) && !r.erasing) begin
            n.ackme = 1'b1;
            if (rx_byte[0]) begin
              n.st = ST_TX;
            end
          end else begin
            n.ackme = 1'b0;
            n.st = ST_SKIP;
          end
        end else if (r.st == ST_TX) begin
          // Master owns the acknowledge slot when reading
          n.ackme = 1'b0;
        end else begin
          // (RL1) Ack every written byte
          n.ackme = 1'b1;
          if (r.byten == 6'h01) begin
            n.cmd = rx_byte;
            // (RL13) Block read command
            if (rx_byte == smbra_pkg::CMD_BLK_RD) begin
              n.blkrd = 1'b1;
            end
            // (RL20) Erase starts at once
            // (RL21) Only when enabled
            if ((rx_byte == smbra_pkg::CMD_ERASE) && erase_en) begin
              erase_go = 1'b1;
              n.busy = smbra_pkg::BUSY_W'(ERASE_CYC);
              n.erasing = 1'b1;
            end
          end else if (is_ram({8'h00, r.cmd})) begin
            // (RL2) Single RAM byte
            // (RL16) A later byte is PEC, not data
            if (r.byten == 6'h02) begin
              wr_en = 1'b1;
              wr_addr = {8'h00, r.cmd};
            end
          end else if (is_ee_hi(r.cmd)) begin
            if (r.byten == 6'h02) begin
              // (RL3) EEPROM pointer load
              n.ptr = {r.cmd, rx_byte};
            end else if (r.byten == 6'h03) begin
              // (RL4) Program one EEPROM byte
              wr_en = 1'b1;
              n.busy = smbra_pkg::BUSY_W'(PROG_CYC);
            end
          end else if (r.cmd == smbra_pkg::CMD_BLK_WR) begin
            if (r.byten == 6'h02) begin
              n.bcnt = rx_byte;
            // (RL6) Block data store
            // (RL7) Bytes past 32 are dropped
            end else if (({2'b00, blk_idx} < r.bcnt) && (blk_idx < smbra_pkg::BLK_MAX)) begin
              wr_en = 1'b1;
              // (RL23) Pointer advance
              n.ptr = r.ptr + 16'h0001;
              if (is_ee(r.ptr)) begin
                n.busy = smbra_pkg::BUSY_W'(PROG_CYC);
              end
            end
          end
        end
      end else if ((r.bitn == 4'h8) && (r.st == ST_TX)) begin
        // Acknowledge clock of a read: a nack from the master ends it
        if ((r.byten > 6'h01) && sda_s) begin
          n.st = ST_SKIP;
        end else if (r.blkrd) begin
          // (RL14) Count then 32 bytes
          if (k_idx == 6'h00) begin
            n.txsh = smbra_pkg::BLK_RD_COUNT;
          end else if (k_idx <= smbra_pkg::BLK_MAX) begin
            n.txsh = mem_rd;
            // (RL23) Pointer advance
            n.ptr = r.ptr + 16'h0001;
          end else if (k_idx == smbra_pkg::PEC_IDX) begin
            // (RL16) PEC after block read
            n.txsh = crc;
          end else begin
            n.txsh = smbra_pkg::IDLE_BYTE;
          end
        end else begin
          // (RL12) Single byte from pointer
          if (k_idx == 6'h00) begin
            n.txsh = mem_rd;
          end else if (k_idx == 6'h01) begin
            n.txsh = crc;
          end else begin
            n.txsh = smbra_pkg::IDLE_BYTE;
          end
        end
      end
    end else if (ev_fall) begin
      // SDA only changes while SCL is low
      if ((r.st == ST_RX) || (r.st == ST_TX)) begin
        if (r.bitn == 4'h8) begin
          n.sda_drv = r.ackme;
        end else if (r.st == ST_TX) begin
          n.sda_drv = ~r.txsh[3'h7 - r.bitn[2:0]];
        end else begin
          n.sda_drv = 1'b0;
        end
        // (RL11) Stretch while programming
        if ((r.bitn == 4'h0) && (r.busy != '0) && !r.erasing) begin
          n.stretch = 1'b1;
        end
      end else begin
        n.sda_drv = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ************************************************************
  // Memories
  // ************************************************************
  // Power-up clears RAM and leaves EEPROM erased; EEPROM can only
  // clear bits when programmed, so rewriting needs an erase first
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < smbra_pkg::RAM_DEPTH; i++) begin
        ram[i] <= 8'h00;
      end
      for (int i = 0; i < smbra_pkg::EE_DEPTH; i++) begin
        ee[i] <= smbra_pkg::EE_ERASED;
      end
    end else begin
      if (wr_en && is_ram(wr_addr)) begin
        ram[wr_addr[7:0]] <= wr_data;
      end
      if (wr_en && is_ee(wr_addr)) begin
        ee[wr_addr[9:0]] <= ee[wr_addr[9:0]] & wr_data;
      end
      // (RL5) Whole 32-byte page
      if (erase_go) begin
        for (int i = 0; i < smbra_pkg::PAGE_BYTES; i++) begin
          ee[{r.ptr[9:5], i[4:0]}] <= smbra_pkg::EE_ERASED;
        end
      end
    end
  end

  // ************************************************************
  // Pins
  // ************************************************************
  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe_out = r.sda_drv;
  assign scl_out = 1'b0;
  assign scl_oe_out = r.stretch;
endmodule

// ==== tb/smbra_slave_props.sv ====
/*
  Pin-level checker for the SMBus RAM/EEPROM slave.
  Assumes a bind to smbra_slave; sees only its ports.
*/
`timescale 1ns/10ps
module smbra_props #(
  parameter int unsigned PROG_CYC = 50,
  parameter int unsigned ERASE_CYC = 200
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic scl_clk_in,
  input wire logic sda_in,
  input wire logic addr_select_hi_pin_in,
  input wire logic addr_select_lo_pin_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic scl_out,
  input wire logic scl_oe_out
);
  int unsigned stretch_r;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Stretch length; a stuck hold would hang the whole bus
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      stretch_r <= 0;
    end else begin
      stretch_r <= scl_oe_out ? stretch_r + 1 : 0;
    end
  end
  property p_scl_low; !scl_out; endproperty
  a_scl_low: assert property (p_scl_low) else $error("scl level not low");
  property p_sda_low; !sda_out; endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda level not low");
  property p_rst_idle; $fell(rst_in) |-> !sda_oe_out && !scl_oe_out; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("lines held at reset");
  property p_sda_chg; $changed(sda_oe_out) |-> !scl_clk_in && $past(scl_clk_in, 8); endproperty
  a_sda_chg: assert property (p_sda_chg) else $error("sda moved off scl fall");
  property p_str_go; $rose(scl_oe_out) |-> !scl_clk_in && $past(scl_clk_in, 8); endproperty
  a_str_go: assert property (p_str_go) else $error("stretch off scl fall");
  property p_str_len; stretch_r <= PROG_CYC + 16; endproperty
  a_str_len: assert property (p_str_len) else $error("stretch too long");
  property p_no_start; $fell(sda_in) && scl_clk_in |-> !sda_oe_out; endproperty
  a_no_start: assert property (p_no_start) else $error("slave made a start");
  property p_stop_free; $rose(sda_in) && scl_clk_in |=> !sda_oe_out [*8]; endproperty
  a_stop_free: assert property (p_stop_free) else $error("sda held after stop");
endmodule
bind smbra_slave smbra_props #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)) smbra_props_i (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .scl_clk_in(scl_clk_in), .sda_in(sda_in),
  .addr_select_hi_pin_in(addr_select_hi_pin_in), .addr_select_lo_pin_in(addr_select_lo_pin_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .scl_out(scl_out), .scl_oe_out(scl_oe_out));

// ==== tb/smbra_master.sv ====
/*
  Behavioural SMBus master pulling SCL and SDA low.
  Assumes the bench resolves both wires with pull-ups.
*/
`timescale 1ns/10ps
module smbra_master (
  input wire logic scl_w_in,
  input wire logic sda_w_in,
  output logic scl_pull_out,
  output logic sda_pull_out
);
  // Half period 42 core clocks, above the slave's minimum
  localparam int HALF = 168;
  int timeouts = 0;
  initial begin
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
  end
  task automatic scl_up();
    int n;
    n = 0;
    scl_pull_out = 1'b0;
    // After one timeout stop waiting, so a hung bus still ends the run soon
    while (scl_w_in !== 1'b1 && n < 2000 && timeouts == 0) begin
      #4;
      n++;
    end
    if (n == 2000) timeouts++;
  endtask
  // Data moves mid low phase, sampled at end of high phase
  task automatic bit_io(input logic tx, output logic rx);
    #(HALF / 2);
    sda_pull_out = !tx;
    #(HALF / 2);
    scl_up();
    #(HALF);
    rx = sda_w_in;
    scl_pull_out = 1'b1;
  endtask
  // Start, also used as repeated start
  task automatic start_c();
    #(HALF / 2);
    sda_pull_out = 1'b0;
    #(HALF / 2);
    scl_up();
    #(HALF);
    sda_pull_out = 1'b1;
    #(HALF);
    scl_pull_out = 1'b1;
  endtask
  task automatic stop_c();
    #(HALF / 2);
    sda_pull_out = 1'b1;
    #(HALF / 2);
    scl_up();
    #(HALF);
    sda_pull_out = 1'b0;
    #(HALF);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

// ==== tb/smbra_slave_bench.sv ====
/*
  Self-checking bench for the SMBus RAM/EEPROM slave.
  Assumes the master model and pull-ups on both bus wires.
*/
`timescale 1ns/10ps
module smbra_slave_bench;
  localparam logic [7:0] ADW = 8'h6c;
  localparam logic [7:0] ADR = 8'h6d;
  logic ref_clk_in, rst_in, hi_pin, lo_pin;
  logic sda_oe, scl_oe, sda_o, scl_o, m_sda, m_scl;
  logic stretch_seen = 1'b0;
  wire logic sda_w, scl_w;
  int num_errors, n_checks;
  // Open-drain wires
  assign sda_w = !(sda_oe | m_sda);
  assign scl_w = !(scl_oe | m_scl);
  // Busy times shortened; programming still outlasts an ack clock so stretch shows
  smbra_slave #(.PROG_CYC(500), .ERASE_CYC(5000)) smbra_slave_i (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .scl_clk_in(scl_w), .sda_in(sda_w),
    .addr_select_hi_pin_in(hi_pin), .addr_select_lo_pin_in(lo_pin), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .scl_out(scl_o), .scl_oe_out(scl_oe));
  smbra_master smbra_master_i (.scl_w_in(scl_w), .sda_w_in(sda_w),
    .scl_pull_out(m_scl), .sda_pull_out(m_sda));
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) if (scl_oe === 1'b1) stretch_seen <= 1'b1;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ smbra_pkg::PEC_POLY) : (r << 1);
    return r;
  endfunction
  task automatic wr(input logic [7:0] q[$], output logic ok);
    logic a;
    ok = 1'b1;
    smbra_master_i.start_c();
    foreach (q[i]) begin
      smbra_master_i.put_byte(q[i], a);
      ok &= a;
    end
    smbra_master_i.stop_c();
  endtask
  task automatic rd1(output logic [7:0] b);
    logic a;
    smbra_master_i.start_c();
    smbra_master_i.put_byte(ADR, a);
    smbra_master_i.get_byte(1'b0, b);
    smbra_master_i.stop_c();
  endtask
  task automatic t_ram();
    logic ok;
    logic [7:0] b;
    wr({ADW, 8'h10, 8'h5a}, ok);
    check({7'h00, ok}, 8'h01);
    wr({ADW, 8'h10}, ok);
    rd1(b);
    check(b, 8'h5a);
    @(posedge ref_clk_in);
    hi_pin <= 1'b0;
    lo_pin <= 1'b1;
    repeat (10) @(posedge ref_clk_in);
    #1;
    wr({ADW, 8'h10, 8'h00}, ok);
    check({7'h00, ok}, 8'h00);
    wr({8'h6a, 8'h10}, ok);
    check({7'h00, ok}, 8'h01);
    @(posedge ref_clk_in);
    hi_pin <= 1'b1;
    lo_pin <= 1'b0;
    repeat (10) @(posedge ref_clk_in);
    #1;
    rd1(b);
    check(b, 8'h5a);
  endtask
  task automatic t_ee();
    logic ok;
    logic [7:0] b;
    wr({ADW, 8'hf8, 8'h03, 8'ha5}, ok);
    check({7'h00, ok}, 8'h01);
    check({7'h00, stretch_seen}, 8'h01);
    wr({ADW, 8'hf8, 8'h03}, ok);
    rd1(b);
    check(b, 8'ha5);
  endtask
  task automatic t_blk();
    logic ok, a;
    logic [7:0] b, e, crc;
    wr({ADW, 8'h20}, ok);
    wr({ADW, smbra_pkg::CMD_BLK_WR, 8'h03, 8'h11, 8'h22, 8'h33}, ok);
    check({7'h00, ok}, 8'h01);
    wr({ADW, 8'h20}, ok);
    smbra_master_i.start_c();
    smbra_master_i.put_byte(ADW, a);
    smbra_master_i.put_byte(smbra_pkg::CMD_BLK_RD, ok);
    ok &= a;
    smbra_master_i.start_c();
    smbra_master_i.put_byte(ADR, a);
    check({7'h00, ok & a}, 8'h01);
    crc = crc8(crc8(crc8(8'h00, ADW), smbra_pkg::CMD_BLK_RD), ADR);
    for (int i = 0; i < 34; i++) begin
      smbra_master_i.get_byte(i < 33, b);
      e = (i == 0) ? 8'h20 : (i < 4) ? 8'(i * 8'h11) : (i < 33) ? 8'h00 : crc;
      check(b, e);
      crc = crc8(crc, e);
    end
    smbra_master_i.stop_c();
  endtask
  task automatic t_erase();
    logic ok;
    logic [7:0] b;
    wr({ADW, smbra_pkg::CMD_ERASE}, ok);
    wr({ADW, 8'hf8, 8'h03}, ok);
    check({7'h00, ok}, 8'h01);
    rd1(b);
    check(b, 8'ha5);
    wr({ADW, 8'h90, 8'h04}, ok);
    wr({ADW, 8'hf8, 8'h1f}, ok);
    wr({ADW, smbra_pkg::CMD_ERASE}, ok);
    wr({ADW, 8'hf8, 8'h03}, ok);
    check({7'h00, ok}, 8'h00);
    repeat (6000) @(posedge ref_clk_in);
    #1;
    wr({ADW, 8'hf8, 8'h03}, ok);
    rd1(b);
    check(b, 8'hff);
    wr({ADW, 8'hf8, 8'h1f}, ok);
    wr({ADW, smbra_pkg::CMD_BLK_WR, 8'h02, 8'h12, 8'h34}, ok);
    check({7'h00, ok}, 8'h01);
    wr({ADW, 8'hf8, 8'h20}, ok);
    rd1(b);
    check(b, 8'h34);
  endtask
  task automatic give_verdict();
    num_errors += smbra_master_i.timeouts;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // A stuck bus wait ends the run once the current test returns
  task automatic step_done(input string name);
    $display("test %s done", name);
    if (smbra_master_i.timeouts != 0) give_verdict();
  endtask
  initial begin
    rst_in = 1'b1;
    hi_pin = 1'b1;
    lo_pin = 1'b0;
    num_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (10) @(posedge ref_clk_in);
    #1.3;
    t_ram();
    step_done("ram");
    t_ee();
    step_done("eeprom");
    t_blk();
    step_done("block");
    t_erase();
    step_done("erase");
    give_verdict();
  end
endmodule
